// ===== hw/supply_status_reporting.sv
// Overview of operation
// - Operation condition shows live flags, unlatched.
// - Operation registers read 0..1313, unused bits zero.
// - Calibrating flag at bit 0, weight 1.
// - Awaiting trigger flag at weight 32.
// - Voltage regulation flag at bit 8.
// - Current regulation flag at bit 10.
// - Operation enable write sets summary mask.
// - Operation summary is OR of enabled events.
// - Operation enable query returns last mask.
// - Operation events latch until read.
// - Operation event read returns then clears.
// - Preset zeroes both condition registers.
// - Questionable enable write reads back bits 0 and 1 of the value, others zero.
// - Overcurrent trip latches event weight 2.
// - Overcurrent flag holds until clear command or preset.
// - Error query answers code zero.
// - Overvoltage bit 0, overcurrent bit 1.
// - Questionable summary is OR of enabled events.
`timescale 1ns/100ps
`default_nettype none

module supply_status_reporting (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic cmd_valid_i,
    input wire status_pkg::status_cmd_e cmd_code_i,
    input wire logic [status_pkg::REG_WIDTH-1:0] cmd_data_i,
    input wire logic calibrating_i,
    input wire logic awaiting_trigger_i,
    input wire logic voltage_regulation_i,
    input wire logic current_regulation_i,
    input wire logic overvoltage_trip_i,
    input wire logic overcurrent_trip_i,
    output logic resp_valid_o,
    output logic [status_pkg::REG_WIDTH-1:0] resp_data_o,
    output logic oper_summary_o,
    output logic ques_summary_o,
    output logic [7:0] status_byte_o
);

    import status_pkg::*;

    logic [LIVE_COUNT-1:0] live_raw;
    logic [LIVE_COUNT-1:0] live_level;

    assign live_raw = {overcurrent_trip_i, overvoltage_trip_i, current_regulation_i,
                       voltage_regulation_i, awaiting_trigger_i, calibrating_i};

    level_sync #(
        .WIDTH(LIVE_COUNT)
    ) u_live_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .async_i(live_raw),
        .level_o(live_level)
    );

    logic calibrating_flag;
    logic awaiting_trigger_flag;
    logic voltage_regulation_flag;
    logic current_regulation_flag;
    logic overvoltage_trip_flag;
    logic overcurrent_trip_flag;

    assign calibrating_flag = live_level[0];
    assign awaiting_trigger_flag = live_level[1];
    assign voltage_regulation_flag = live_level[2];
    assign current_regulation_flag = live_level[3];
    assign overvoltage_trip_flag = live_level[4];
    assign overcurrent_trip_flag = live_level[5];

    // The trip inputs only feed edge detection below; the questionable
    // condition is the trip latch, so a trip that drops still reads set.
    logic [REG_WIDTH-1:0] oper_live;
    logic [REG_WIDTH-1:0] ques_live;

    always_comb begin
        oper_live = REG_RESET_VALUE;
        oper_live[OPER_CAL_BIT] = calibrating_flag;
        oper_live[OPER_TRIG_WAIT_BIT] = awaiting_trigger_flag;
        oper_live[OPER_CVR_BIT] = voltage_regulation_flag;
        oper_live[OPER_CCR_BIT] = current_regulation_flag;
        ques_live = REG_RESET_VALUE;
        ques_live[QUES_OVT_BIT] = overvoltage_trip_flag;
        ques_live[QUES_OCT_BIT] = overcurrent_trip_flag;
    end

    // Command decode, one strobe per accepted command.
    // A held strobe is decoded afresh every cycle, so commands may run back to back.
    logic do_oper_cond_q;
    logic do_oper_enab_w;
    logic do_oper_enab_q;
    logic do_oper_event_q;
    logic do_preset;
    logic do_ques_cond_q;
    logic do_ques_enab_w;
    logic do_ques_enab_q;
    logic do_ques_event_q;
    logic do_overvolt_clear;
    logic do_overcurr_clear;
    logic do_err_q;

    always_comb begin
        do_oper_cond_q = 1'b0;
        do_oper_enab_w = 1'b0;
        do_oper_enab_q = 1'b0;
        do_oper_event_q = 1'b0;
        do_preset = 1'b0;
        do_ques_cond_q = 1'b0;
        do_ques_enab_w = 1'b0;
        do_ques_enab_q = 1'b0;
        do_ques_event_q = 1'b0;
        do_overvolt_clear = 1'b0;
        do_overcurr_clear = 1'b0;
        do_err_q = 1'b0;
        if (cmd_valid_i) begin
            unique case (cmd_code_i)
                CMD_OPER_COND_QUERY: do_oper_cond_q = 1'b1;
                CMD_OPER_ENABLE_WRITE: do_oper_enab_w = 1'b1;
                CMD_OPER_ENABLE_QUERY: do_oper_enab_q = 1'b1;
                CMD_OPER_EVENT_QUERY: do_oper_event_q = 1'b1;
                CMD_STATUS_PRESET: do_preset = 1'b1;
                CMD_QUES_COND_QUERY: do_ques_cond_q = 1'b1;
                CMD_QUES_ENABLE_WRITE: do_ques_enab_w = 1'b1;
                CMD_QUES_ENABLE_QUERY: do_ques_enab_q = 1'b1;
                CMD_QUES_EVENT_QUERY: do_ques_event_q = 1'b1;
                CMD_OVERVOLTAGE_CLEAR: do_overvolt_clear = 1'b1;
                CMD_OVERCURRENT_CLEAR: do_overcurr_clear = 1'b1;
                CMD_ERROR_QUERY: do_err_q = 1'b1;
                // Codes outside the set are ignored and get no answer.
                default: ;
            endcase
        end
    end

    logic [REG_WIDTH-1:0] oper_cond_reg;
    logic [REG_WIDTH-1:0] oper_cond_next;
    logic [REG_WIDTH-1:0] oper_enab_reg;
    logic [REG_WIDTH-1:0] oper_enab_next;
    logic [REG_WIDTH-1:0] oper_event_reg;
    logic [REG_WIDTH-1:0] oper_event_next;
    logic [REG_WIDTH-1:0] oper_prev_reg;
    logic [REG_WIDTH-1:0] ques_trip_reg;
    logic [REG_WIDTH-1:0] ques_trip_next;
    logic [REG_WIDTH-1:0] ques_enab_reg;
    logic [REG_WIDTH-1:0] ques_enab_next;
    logic [REG_WIDTH-1:0] ques_event_reg;
    logic [REG_WIDTH-1:0] ques_event_next;
    logic [REG_WIDTH-1:0] ques_prev_reg;
    logic [REG_WIDTH-1:0] oper_rise;
    logic [REG_WIDTH-1:0] ques_rise;
    logic [REG_WIDTH-1:0] ques_clear;
    logic oper_summary_reg;
    logic oper_summary_next;
    logic ques_summary_reg;
    logic ques_summary_next;

    // Events come from rising edges of the live inputs rather than of the
    // condition registers, so a preset does not fake events on release.
    always_comb begin
        oper_rise = oper_live & ~oper_prev_reg & OPER_IMPL_MASK;
        ques_rise = ques_live & ~ques_prev_reg & QUES_IMPL_MASK;
        ques_clear = REG_RESET_VALUE;
        ques_clear[QUES_OVT_BIT] = do_overvolt_clear;
        ques_clear[QUES_OCT_BIT] = do_overcurr_clear;

        // Preset blanks the live condition for one cycle only; with no latch
        // behind it the next edge shows the inputs again.
        oper_cond_next = oper_live & OPER_IMPL_MASK;
        if (do_preset) begin
            oper_cond_next = REG_RESET_VALUE;
        end

        // A trip holds until its clear command or a preset; a new trip in the same
        // cycle as the clear keeps the flag set.
        ques_trip_next = ((ques_trip_reg & ~ques_clear) | ques_rise) & QUES_IMPL_MASK;
        if (do_preset) begin
            ques_trip_next = ques_rise;
        end

        oper_enab_next = oper_enab_reg;
        if (do_oper_enab_w) begin
            oper_enab_next = cmd_data_i & OPER_IMPL_MASK;
        end
        ques_enab_next = ques_enab_reg;
        if (do_ques_enab_w) begin
            ques_enab_next = cmd_data_i & QUES_IMPL_MASK;
        end

        // Read clears, but an event arriving in the read cycle survives.
        oper_event_next = oper_event_reg;
        if (do_oper_event_q) begin
            oper_event_next = REG_RESET_VALUE;
        end
        oper_event_next = oper_event_next | oper_rise;
        ques_event_next = ques_event_reg;
        if (do_ques_event_q) begin
            ques_event_next = REG_RESET_VALUE;
        end
        ques_event_next = ques_event_next | ques_rise;

        // Summaries follow the next event and mask values, so they move on
        // the same edge as the registers they summarise.
        oper_summary_next = |(oper_event_next & oper_enab_next);
        ques_summary_next = |(ques_event_next & ques_enab_next);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            oper_cond_reg <= REG_RESET_VALUE;
            oper_enab_reg <= REG_RESET_VALUE;
            oper_event_reg <= REG_RESET_VALUE;
            oper_prev_reg <= REG_RESET_VALUE;
            ques_trip_reg <= REG_RESET_VALUE;
            ques_enab_reg <= REG_RESET_VALUE;
            ques_event_reg <= REG_RESET_VALUE;
            ques_prev_reg <= REG_RESET_VALUE;
            oper_summary_reg <= 1'b0;
            ques_summary_reg <= 1'b0;
        end else begin
            oper_cond_reg <= oper_cond_next;
            oper_enab_reg <= oper_enab_next;
            oper_event_reg <= oper_event_next;
            oper_prev_reg <= oper_live;
            ques_trip_reg <= ques_trip_next;
            ques_enab_reg <= ques_enab_next;
            ques_event_reg <= ques_event_next;
            ques_prev_reg <= ques_live;
            oper_summary_reg <= oper_summary_next;
            ques_summary_reg <= ques_summary_next;
        end
    end

    // Query answers: the value held at the query cycle, one cycle later.
    logic resp_valid_reg;
    logic resp_valid_next;
    logic [REG_WIDTH-1:0] resp_data_reg;
    logic [REG_WIDTH-1:0] resp_data_next;

    always_comb begin
        resp_valid_next = 1'b0;
        resp_data_next = resp_data_reg;
        if (do_oper_cond_q) begin
            resp_valid_next = 1'b1;
            resp_data_next = oper_cond_reg;
        end else if (do_oper_enab_q) begin
            resp_valid_next = 1'b1;
            resp_data_next = oper_enab_reg;
        end else if (do_oper_event_q) begin
            resp_valid_next = 1'b1;
            resp_data_next = oper_event_reg;
        end else if (do_ques_cond_q) begin
            resp_valid_next = 1'b1;
            resp_data_next = ques_trip_reg;
        end else if (do_ques_enab_q) begin
            resp_valid_next = 1'b1;
            resp_data_next = ques_enab_reg;
        end else if (do_ques_event_q) begin
            resp_valid_next = 1'b1;
            resp_data_next = ques_event_reg;
        end else if (do_err_q) begin
            resp_valid_next = 1'b1;
            resp_data_next = ERR_NONE_CODE;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            resp_valid_reg <= 1'b0;
            resp_data_reg <= REG_RESET_VALUE;
        end else begin
            resp_valid_reg <= resp_valid_next;
            resp_data_reg <= resp_data_next;
        end
    end

    logic [7:0] status_byte_reg;
    logic [7:0] status_byte_next;

    // The status byte is registered from the same next values as the
    // summary flops, so its bits never lag the separate summary outputs.
    always_comb begin
        status_byte_next = 8'h00;
        status_byte_next[STB_OPER_SUMMARY_BIT] = oper_summary_next;
        status_byte_next[STB_QUES_SUMMARY_BIT] = ques_summary_next;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            status_byte_reg <= 8'h00;
        end else begin
            status_byte_reg <= status_byte_next;
        end
    end

    assign resp_valid_o = resp_valid_reg;
    assign resp_data_o = resp_data_reg;
    assign oper_summary_o = oper_summary_reg;
    assign ques_summary_o = ques_summary_reg;
    assign status_byte_o = status_byte_reg;

endmodule : supply_status_reporting

`default_nettype wire

// ===== hw/status_pkg.sv
package status_pkg;

    localparam int unsigned REG_WIDTH = 16;

    // Operation register bit positions.
    localparam int unsigned OPER_CAL_BIT = 0;
    localparam int unsigned OPER_TRIG_WAIT_BIT = 5;
    localparam int unsigned OPER_CVR_BIT = 8;
    localparam int unsigned OPER_CCR_BIT = 10;

    // Questionable register bit positions.
    localparam int unsigned QUES_OVT_BIT = 0;
    localparam int unsigned QUES_OCT_BIT = 1;

    // Implemented-bit masks; every other bit reads zero.
    localparam logic [15:0] OPER_IMPL_MASK = 16'h0521;
    localparam logic [15:0] QUES_IMPL_MASK = 16'h0003;

    // Reset values of conditions, events, masks and answers.
    localparam logic [15:0] REG_RESET_VALUE = 16'h0000;

    // Status byte bit positions of the two summary bits.
    localparam int unsigned STB_OPER_SUMMARY_BIT = 7;
    localparam int unsigned STB_QUES_SUMMARY_BIT = 3;

    // Answer to an error queue query with nothing pending.
    localparam logic [15:0] ERR_NONE_CODE = 16'h0000;

    // Number of live condition inputs that pass the synchroniser.
    localparam int unsigned LIVE_COUNT = 6;

    typedef enum logic [3:0] {
        CMD_OPER_COND_QUERY,
        CMD_OPER_ENABLE_WRITE,
        CMD_OPER_ENABLE_QUERY,
        CMD_OPER_EVENT_QUERY,
        CMD_STATUS_PRESET,
        CMD_QUES_COND_QUERY,
        CMD_QUES_ENABLE_WRITE,
        CMD_QUES_ENABLE_QUERY,
        CMD_QUES_EVENT_QUERY,
        CMD_OVERVOLTAGE_CLEAR,
        CMD_OVERCURRENT_CLEAR,
        CMD_ERROR_QUERY
    } status_cmd_e;

endpackage : status_pkg

// ===== hw/level_sync.sv
`timescale 1ns/100ps
`default_nettype none

module level_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] level_o
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;
    logic [WIDTH-1:0] level_reg;
    logic [WIDTH-1:0] level_next;

    // A change is accepted only when the second and third stages agree,
    // so a value caught mid-transition never reaches the block.
    always_comb begin
        level_next = level_reg;
        for (int i = 0; i < WIDTH; i++) begin
            if (stage2_reg[i] == stage3_reg[i]) begin
                level_next[i] = stage3_reg[i];
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
            level_reg <= '0;
        end else begin
            stage1_reg <= async_i;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            level_reg <= level_next;
        end
    end

    assign level_o = level_reg;

endmodule : level_sync

`default_nettype wire

// ===== bench/supply_status_props.sv
`timescale 1ns/100ps
`default_nettype none

module supply_status_props (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic cmd_valid_i,
    input wire status_pkg::status_cmd_e cmd_code_i,
    input wire logic [15:0] cmd_data_i,
    input wire logic resp_valid_o,
    input wire logic [15:0] resp_data_o,
    input wire logic oper_summary_o,
    input wire logic ques_summary_o,
    input wire logic [7:0] status_byte_o
);
    import status_pkg::*;
    logic take_query;
    logic take_oper;
    logic take_ques;
    assign take_oper = cmd_valid_i && (cmd_code_i inside {CMD_OPER_COND_QUERY, CMD_OPER_ENABLE_QUERY,
        CMD_OPER_EVENT_QUERY});
    assign take_ques = cmd_valid_i && (cmd_code_i inside {CMD_QUES_COND_QUERY, CMD_QUES_ENABLE_QUERY,
        CMD_QUES_EVENT_QUERY});
    assign take_query = take_oper || take_ques || (cmd_valid_i && cmd_code_i == CMD_ERROR_QUERY);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence oper_mask_s;
        cmd_valid_i && cmd_code_i == CMD_OPER_ENABLE_WRITE ##1 cmd_valid_i && cmd_code_i == CMD_OPER_ENABLE_QUERY;
    endsequence
    sequence oper_off_s;
        cmd_valid_i && cmd_code_i == CMD_OPER_ENABLE_WRITE && cmd_data_i == 16'h0000;
    endsequence
    sequence ques_off_s;
        cmd_valid_i && cmd_code_i == CMD_QUES_ENABLE_WRITE && cmd_data_i == 16'h0000;
    endsequence
    sequence ques_mask_s;
        cmd_valid_i && cmd_code_i == CMD_QUES_ENABLE_WRITE ##1 cmd_valid_i && cmd_code_i == CMD_QUES_ENABLE_QUERY;
    endsequence
    AST_OPER_MASK_BACK: assert property (oper_mask_s |=> resp_data_o == ($past(cmd_data_i, 2) & OPER_IMPL_MASK))
        else $error("operation mask readback differs from written value");
    AST_QUES_MASK_BACK: assert property (ques_mask_s |=> resp_data_o == ($past(cmd_data_i, 2) & QUES_IMPL_MASK))
        else $error("questionable mask readback differs from written value");
    AST_QUERY_ANSWER: assert property (take_query |=> resp_valid_o)
        else $error("query not answered in the next cycle");
    AST_NO_ANSWER: assert property (!take_query |=> !resp_valid_o)
        else $error("answer without a query");
    AST_OPER_UNUSED: assert property (take_oper |=> (resp_data_o & ~OPER_IMPL_MASK) == 16'h0000)
        else $error("operation answer has unused bits set");
    AST_QUES_UNUSED: assert property (take_ques |=> (resp_data_o & ~QUES_IMPL_MASK) == 16'h0000)
        else $error("questionable answer has unused bits set");
    AST_ERROR_ZERO: assert property (cmd_valid_i && cmd_code_i == CMD_ERROR_QUERY |=> resp_data_o == ERR_NONE_CODE)
        else $error("error query answer not zero");
    AST_STB_LAYOUT: assert property (status_byte_o == {oper_summary_o, 3'h0, ques_summary_o, 3'h0})
        else $error("status byte layout wrong");
    AST_OPER_MASK_OFF: assert property (oper_off_s |=> !oper_summary_o)
        else $error("operation summary set with empty mask");
    AST_QUES_MASK_OFF: assert property (ques_off_s |=> !ques_summary_o)
        else $error("questionable summary set with empty mask");
    AST_RESET_QUIET: assert property (disable iff (1'b0) !rst_n_i |=> status_byte_o == 8'h00 && !resp_valid_o)
        else $error("outputs not cleared by reset");
endmodule : supply_status_props

bind supply_status_reporting supply_status_props supply_status_props_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
    .cmd_data_i(cmd_data_i), .resp_valid_o(resp_valid_o), .resp_data_o(resp_data_o),
    .oper_summary_o(oper_summary_o), .ques_summary_o(ques_summary_o), .status_byte_o(status_byte_o));

`default_nettype wire

// ===== bench/remote_host.sv
`timescale 1ns/100ps
`default_nettype none

module remote_host (
    input wire logic clk_sys_i,
    input wire logic resp_valid_i,
    input wire logic [15:0] resp_data_i,
    output logic cmd_valid_o,
    output var status_pkg::status_cmd_e cmd_code_o,
    output logic [15:0] cmd_data_o
);
    import status_pkg::*;
    initial begin
        cmd_valid_o = 1'b0;
        cmd_code_o = CMD_ERROR_QUERY;
        cmd_data_o = 16'h0000;
    end
    task automatic send(input status_cmd_e code, input logic [15:0] data);
        @(negedge clk_sys_i);
        cmd_valid_o = 1'b1;
        cmd_code_o = code;
        cmd_data_o = data;
    endtask : send
    // Data toggles while idle so that nothing can lean on a stale word.
    task automatic idle();
        @(negedge clk_sys_i);
        cmd_valid_o = 1'b0;
        cmd_data_o = ~cmd_data_o;
    endtask : idle
    task automatic wait_resp(output logic [15:0] data, output logic ok);
        ok = 1'b0;
        data = 16'h0000;
        for (int n = 0; n < 4 && !ok; n++) begin
            if (resp_valid_i === 1'b1) begin
                data = resp_data_i;
                ok = 1'b1;
            end else begin
                @(negedge clk_sys_i);
            end
        end
    endtask : wait_resp
    task automatic query(input status_cmd_e code, output logic [15:0] data, output logic ok);
        send(code, 16'h0000);
        idle();
        wait_resp(data, ok);
    endtask : query
    // Write and query go out in consecutive cycles, the tightest legal spacing.
    task automatic write_read(input status_cmd_e w, input status_cmd_e q, input logic [15:0] wd,
        output logic [15:0] data, output logic ok);
        send(w, wd);
        send(q, 16'h0000);
        idle();
        wait_resp(data, ok);
    endtask : write_read
endmodule : remote_host

`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import status_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cmd_valid;
    status_cmd_e cmd_code;
    logic [15:0] cmd_data;
    logic [5:0] cond = 6'h00;
    logic resp_valid;
    logic [15:0] resp_data;
    logic [7:0] status_byte;
    logic oper_sum;
    logic ques_sum;
    int errors = 0;
    int checked = 0;

    always #25 clk_sys_i = ~clk_sys_i;

    supply_status_reporting supply_status_reporting_inst (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code),
        .cmd_data_i(cmd_data), .calibrating_i(cond[0]), .awaiting_trigger_i(cond[1]),
        .voltage_regulation_i(cond[2]), .current_regulation_i(cond[3]), .overvoltage_trip_i(cond[4]),
        .overcurrent_trip_i(cond[5]), .resp_valid_o(resp_valid), .resp_data_o(resp_data),
        .oper_summary_o(oper_sum), .ques_summary_o(ques_sum), .status_byte_o(status_byte));
    remote_host remote_host_inst (
        .clk_sys_i(clk_sys_i), .resp_valid_i(resp_valid), .resp_data_i(resp_data),
        .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code), .cmd_data_o(cmd_data));

    task automatic stop_test();
        if (errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic ask(input status_cmd_e c, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        remote_host_inst.query(c, d, ok);
        if (ok !== 1'b1) begin
            errors++;
            stop_test();
        end else begin
            check(c.name(), exp, d);
        end
    endtask : ask
    task automatic wr_rd(input status_cmd_e w, input status_cmd_e q, input logic [15:0] wd, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        remote_host_inst.write_read(w, q, wd, d, ok);
        if (ok !== 1'b1) begin
            errors++;
            stop_test();
        end else begin
            check(q.name(), exp, d);
        end
    endtask : wr_rd
    task automatic issue(input status_cmd_e c);
        remote_host_inst.send(c, 16'h0000);
        remote_host_inst.idle();
    endtask : issue
    task automatic stb(input logic [7:0] e);
        check("status byte", {8'h00, e}, {8'h00, status_byte});
        check("operation summary", {15'h0000, e[7]}, {15'h0000, oper_sum});
        check("questionable summary", {15'h0000, e[3]}, {15'h0000, ques_sum});
    endtask : stb
    // Condition changes need the synchroniser plus the latch stage before they show.
    task automatic settle();
        repeat (8) @(negedge clk_sys_i);
    endtask : settle

    initial begin
        repeat (3) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        ask(CMD_OPER_ENABLE_QUERY, 16'h0000);
        ask(CMD_QUES_ENABLE_QUERY, 16'h0000);
        ask(CMD_OPER_EVENT_QUERY, 16'h0000);
        ask(CMD_QUES_COND_QUERY, 16'h0000);
        stb(8'h00);
        wr_rd(CMD_OPER_ENABLE_WRITE, CMD_OPER_ENABLE_QUERY, 16'hffff, 16'h0521);
        wr_rd(CMD_OPER_ENABLE_WRITE, CMD_OPER_ENABLE_QUERY, 16'h0420, 16'h0420);
        issue(CMD_STATUS_PRESET);
        cond = 6'h06;
        settle();
        ask(CMD_OPER_COND_QUERY, 16'h0120);
        stb(8'h80);
        ask(CMD_OPER_EVENT_QUERY, 16'h0120);
        ask(CMD_OPER_EVENT_QUERY, 16'h0000);
        stb(8'h00);
        cond = 6'h0f;
        settle();
        ask(CMD_OPER_COND_QUERY, 16'h0521);
        stb(8'h80);
        ask(CMD_OPER_EVENT_QUERY, 16'h0401);
        wr_rd(CMD_STATUS_PRESET, CMD_OPER_COND_QUERY, 16'h0000, 16'h0000);
        ask(CMD_OPER_COND_QUERY, 16'h0521);
        cond = 6'h00;
        settle();
        ask(CMD_OPER_COND_QUERY, 16'h0000);
        ask(CMD_OPER_EVENT_QUERY, 16'h0000);
        wr_rd(CMD_QUES_ENABLE_WRITE, CMD_QUES_ENABLE_QUERY, 16'h0003, 16'h0003);
        cond = 6'h20;
        settle();
        stb(8'h08);
        ask(CMD_QUES_EVENT_QUERY, 16'h0002);
        ask(CMD_QUES_EVENT_QUERY, 16'h0000);
        ask(CMD_QUES_COND_QUERY, 16'h0002);
        cond = 6'h00;
        settle();
        ask(CMD_QUES_COND_QUERY, 16'h0002);
        issue(CMD_OVERCURRENT_CLEAR);
        ask(CMD_QUES_COND_QUERY, 16'h0000);
        cond = 6'h10;
        settle();
        ask(CMD_QUES_EVENT_QUERY, 16'h0001);
        ask(CMD_QUES_COND_QUERY, 16'h0001);
        issue(CMD_OVERVOLTAGE_CLEAR);
        ask(CMD_QUES_COND_QUERY, 16'h0000);
        cond = 6'h20;
        settle();
        stb(8'h08);
        issue(CMD_STATUS_PRESET);
        ask(CMD_QUES_COND_QUERY, 16'h0000);
        wr_rd(CMD_QUES_ENABLE_WRITE, CMD_QUES_ENABLE_QUERY, 16'h0000, 16'h0000);
        wr_rd(CMD_OPER_ENABLE_WRITE, CMD_OPER_ENABLE_QUERY, 16'h0000, 16'h0000);
        stb(8'h00);
        ask(CMD_ERROR_QUERY, 16'h0000);
        stop_test();
    end
endmodule : tb_top

`default_nettype wire
